// >>> ssiu_pkg.sv
`default_nettype none
package ssiu_pkg;
  // datapath widths
  localparam int unsigned DATA_W   = 64;
  localparam int unsigned ADDR_W   = 32;
  localparam int unsigned IDX_W    = 3;
  localparam int unsigned NREG     = 8;
  localparam int unsigned PARCEL_W = 6;
  localparam int unsigned FUNNEL_W = 128;

  // clock and phase timing, two phases per clock period
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned PHASES_PER_CLK = 2;
  localparam int unsigned NEXT_ISSUE_PH  = 2;
  localparam int unsigned AREG_FREE_PH   = 3;
  localparam int unsigned SREG_FREE_PH   = 5;
  localparam int unsigned VLU_FREE_PH    = 6;
  localparam int unsigned LONG_WR_PH     = 14;
  localparam int unsigned LONG_REL_PH    = 15;
  localparam int unsigned IMM_WR_PH      = 6;
  localparam int unsigned IMM_REL_PH     = 7;
  localparam int unsigned LOAD_HOLD_PH   = 4;

  // phase figures turned into clock counts after the issue edge
  localparam int unsigned LONG_WR_CYC = LONG_WR_PH / PHASES_PER_CLK;
  localparam int unsigned IMM_WR_CYC  = IMM_WR_PH / PHASES_PER_CLK;
  localparam int unsigned HOLD_CYC    = LOAD_HOLD_PH / PHASES_PER_CLK;
  localparam int unsigned PIPE_DEPTH  = LONG_WR_CYC - 1;
  localparam int unsigned IMM_INJECT  = LONG_WR_CYC - IMM_WR_CYC;
  localparam int unsigned RSV_W       = LONG_WR_CYC + 1;

  // counts and reset values
  localparam logic [FUNNEL_W-1:0] FUNNEL_ZERO   = '0;
  localparam logic [ADDR_W-1:0]   MAX_DBL_COUNT = 32'h0000_0080;
  localparam logic [1:0]          HOLD_RESET    = 2'h0;
  localparam logic [1:0]          HOLD_LOAD     = 2'(HOLD_CYC);

  // operation select, the low octal digit of the operation code
  typedef enum logic [2:0] {
    OP_SHL_IMM  = 3'h0,
    OP_SHR_IMM  = 3'h1,
    OP_SHL_DBL  = 3'h2,
    OP_SHR_DBL  = 3'h3,
    OP_MASK_CPY = 3'h4,
    OP_RTC_READ = 3'h5,
    OP_IMM_POS  = 3'h6,
    OP_IMM_NEG  = 3'h7
  } ssiu_op_t;

  typedef enum logic [1:0] {
    SLOT_EMPTY = 2'b01,
    SLOT_HELD  = 2'b10
  } ssiu_slot_t;
endpackage
`default_nettype wire

// >>> ssiu_result_unit.sv
`default_nettype none
module ssiu_result_unit
  import ssiu_pkg::*;
(
  // operation
  input  wire ssiu_op_t              i_op,
  input  wire logic [PARCEL_W-1:0]   i_parcel,
  // operands
  input  wire logic [DATA_W-1:0]     i_dest_data,
  input  wire logic [DATA_W-1:0]     i_src_data,
  input  wire logic [ADDR_W-1:0]     i_count_data,
  input  wire logic [DATA_W-1:0]     i_vmask,
  input  wire logic [DATA_W-1:0]     i_rtc,
  // result
  output logic      [DATA_W-1:0]     o_result
);
  logic [FUNNEL_W-1:0] left_field;
  logic [FUNNEL_W-1:0] right_field;
  logic [7:0]          dbl_count;
  logic                dbl_zero;

  assign dbl_zero    = i_count_data > MAX_DBL_COUNT;
  assign dbl_count   = i_count_data[7:0];
  // count 128 shifts everything out of the field on its own
  assign left_field  = {i_dest_data, i_src_data} << dbl_count;
  assign right_field = {i_src_data, i_dest_data} >> dbl_count;

  always_comb begin
    unique case (i_op)
      OP_SHL_IMM:  o_result = i_dest_data << i_parcel;
      OP_SHR_IMM:  o_result = i_dest_data >> i_parcel;
      OP_SHL_DBL:  o_result = dbl_zero ? '0 : left_field[FUNNEL_W-1:DATA_W];
      OP_SHR_DBL:  o_result = dbl_zero ? '0 : right_field[DATA_W-1:0];
      OP_MASK_CPY: o_result = i_vmask;
      OP_RTC_READ: o_result = i_rtc;
      OP_IMM_POS:  o_result = {{(DATA_W-PARCEL_W){1'b0}}, i_parcel};
      OP_IMM_NEG:  o_result = {{(DATA_W-PARCEL_W){1'b1}}, i_parcel};
    endcase
  end
endmodule // ssiu_result_unit
`default_nettype wire

// >>> ssiu_load_hold.sv
`default_nettype none
module ssiu_load_hold
  import ssiu_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // events
  input  wire logic i_load_issued,
  input  wire logic i_other_issued,
  // hold
  output logic      o_hold
);
  logic [1:0] remain;

  // another issue in between breaks the back-to-back pairing
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      remain <= HOLD_RESET;
    end else if (i_load_issued) begin
      remain <= HOLD_LOAD;
    end else if (i_other_issued) begin
      remain <= HOLD_RESET;
    end else if (remain != HOLD_RESET) begin
      remain <= remain - 2'h1;
    end
  end

  assign o_hold = remain != HOLD_RESET;
endmodule // ssiu_load_hold
`default_nettype wire

// >>> ssiu_unit.sv
`default_nettype none
// Behaviour
// - immediate left shift of destination by six-bit parcel count, 0 to 63.
// - left shifts insert zeros at the bottom, bits off the top are lost.
// - immediate right shift of destination by six-bit parcel count, 0 to 63.
// - right shifts insert zeros at the top, no sign fill or rotation.
// - double left shift uses destination high, source low, 128-bit field.
// - double right shift uses source high, destination low, 128-bit field.
// - double shifts return the window where the destination started.
// - double shift count is the address register, unsigned 32 bits.
// - count above 128 gives zero, 64 gives source, 0 keeps destination.
// - mask copy moves full 64-bit vector mask into destination.
// - mask copy held two clocks after back-to-back mask load.
// - counter read moves full 64-bit real-time counter into destination.
// - counter read held two clocks after back-to-back counter load.
// - positive immediate: parcel in low six bits, upper bits zero.
// - negative immediate: parcel in low six bits, upper bits one.
// - shifts and copies write in phase 14, release destination phase 15.
// - double shift needs count register by phase 3, operands by 5.
// - copies need vector logical unit and its resource free in phase 6.
// - immediates write in phase 6, release destination in phase 7.
// - next instruction may enter the issue position in phase 2.
// - nothing issues unless its destination register is free by phase 5.
module ssiu_unit
  import ssiu_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  // issue request
  input  wire logic              i_issue_valid,
  input  wire ssiu_op_t          i_op,
  input  wire logic [IDX_W-1:0]  i_dest_idx,
  input  wire logic [IDX_W-1:0]  i_src_idx,
  input  wire logic [IDX_W-1:0]  i_count_idx,
  input  wire logic [PARCEL_W-1:0] i_parcel,
  output logic                   o_slot_full,
  output ssiu_op_t               o_held_op,
  output logic [IDX_W-1:0]       o_held_dest_idx,
  output logic [IDX_W-1:0]       o_held_src_idx,
  output logic [IDX_W-1:0]       o_held_count_idx,
  output logic                   o_issued,
  // resource status
  input  wire logic [NREG-1:0]   i_sreg_free,
  input  wire logic [NREG-1:0]   i_areg_free,
  input  wire logic              i_vlu_free,
  input  wire logic              i_mask_free,
  input  wire logic              i_rtc_free,
  input  wire logic [RSV_W-1:0]  i_wpath_rsv,
  input  wire logic              i_vm_load_issued,
  input  wire logic              i_rtc_load_issued,
  // operand data
  input  wire logic [DATA_W-1:0] i_dest_data,
  input  wire logic [DATA_W-1:0] i_src_data,
  input  wire logic [ADDR_W-1:0] i_count_data,
  input  wire logic [DATA_W-1:0] i_vmask,
  input  wire logic [DATA_W-1:0] i_rtc,
  // reservation and write back
  output logic                   o_dest_reserve,
  output logic [IDX_W-1:0]       o_reserve_idx,
  output logic                   o_wr_valid,
  output logic [IDX_W-1:0]       o_wr_idx,
  output logic [DATA_W-1:0]      o_wr_data,
  output logic                   o_dest_release,
  output logic [IDX_W-1:0]       o_release_idx
);
  ssiu_slot_t          slot;
  ssiu_slot_t          next_slot;
  ssiu_op_t            held_op;
  logic [IDX_W-1:0]    held_dest;
  logic [IDX_W-1:0]    held_src;
  logic [IDX_W-1:0]    held_count;
  logic [PARCEL_W-1:0] held_parcel;

  ssiu_op_t            cur_op;
  logic [IDX_W-1:0]    cur_dest;
  logic [IDX_W-1:0]    cur_src;
  logic [IDX_W-1:0]    cur_count;
  logic [PARCEL_W-1:0] cur_parcel;
  logic                cur_valid;
  logic                cur_is_dbl;
  logic                cur_is_copy;
  logic                cur_is_imm;
  logic                ok_dest;
  logic                ok_dbl;
  logic                ok_copy;
  logic                ok_path;
  logic                fire;
  logic                take;
  logic                vm_hold;
  logic                rtc_hold;
  logic [DATA_W-1:0]   result;
  logic                issued_long;

  logic                pipe_valid [PIPE_DEPTH];
  logic [IDX_W-1:0]    pipe_idx   [PIPE_DEPTH];
  logic [DATA_W-1:0]   pipe_data  [PIPE_DEPTH];

  // the issue position is the held slot, or the incoming request when empty
  always_comb begin
    if (slot == SLOT_HELD) begin
      cur_valid  = 1'b1;
      cur_op     = held_op;
      cur_dest   = held_dest;
      cur_src    = held_src;
      cur_count  = held_count;
      cur_parcel = held_parcel;
    end else begin
      cur_valid  = i_issue_valid;
      cur_op     = i_op;
      cur_dest   = i_dest_idx;
      cur_src    = i_src_idx;
      cur_count  = i_count_idx;
      cur_parcel = i_parcel;
    end
  end

  assign cur_is_dbl  = cur_op == OP_SHL_DBL || cur_op == OP_SHR_DBL;
  assign cur_is_copy = cur_op == OP_MASK_CPY || cur_op == OP_RTC_READ;
  assign cur_is_imm  = cur_op == OP_IMM_POS || cur_op == OP_IMM_NEG;

  assign ok_dest = i_sreg_free[cur_dest];
  assign ok_dbl  = !cur_is_dbl || (i_areg_free[cur_count] && i_sreg_free[cur_src]);

  // a load of the same resource right before forces a two clock hold
  always_comb begin
    ok_copy = 1'b1;
    if (cur_op == OP_MASK_CPY) begin
      ok_copy = i_vlu_free && i_mask_free && !vm_hold;
    end else if (cur_op == OP_RTC_READ) begin
      ok_copy = i_vlu_free && i_rtc_free && !rtc_hold;
    end
  end

  // an immediate joins the pipe mid-way and must not land on an older result
  always_comb begin
    if (cur_is_imm) begin
      ok_path = !i_wpath_rsv[IMM_WR_CYC] && !pipe_valid[IMM_INJECT-1];
    end else begin
      ok_path = !i_wpath_rsv[LONG_WR_CYC];
    end
  end

  assign fire = cur_valid && ok_dest && ok_dbl && ok_copy && ok_path;
  assign take = slot == SLOT_EMPTY && i_issue_valid && !fire;

  always_comb begin
    unique case (slot)
      SLOT_EMPTY: next_slot = take ? SLOT_HELD : SLOT_EMPTY;
      SLOT_HELD:  next_slot = fire ? SLOT_EMPTY : SLOT_HELD;
      default:    next_slot = SLOT_EMPTY;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      slot <= SLOT_EMPTY;
    end else begin
      slot <= next_slot;
    end
  end

  // a held operation is kept exactly as it arrived
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      held_op     <= OP_SHL_IMM;
      held_dest   <= '0;
      held_src    <= '0;
      held_count  <= '0;
      held_parcel <= '0;
    end else if (take) begin
      held_op     <= i_op;
      held_dest   <= i_dest_idx;
      held_src    <= i_src_idx;
      held_count  <= i_count_idx;
      held_parcel <= i_parcel;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_slot_full      <= 1'b0;
      o_held_op        <= OP_SHL_IMM;
      o_held_dest_idx  <= '0;
      o_held_src_idx   <= '0;
      o_held_count_idx <= '0;
    end else begin
      o_slot_full      <= next_slot == SLOT_HELD;
      o_held_op        <= take ? i_op : held_op;
      o_held_dest_idx  <= take ? i_dest_idx : held_dest;
      o_held_src_idx   <= take ? i_src_idx : held_src;
      o_held_count_idx <= take ? i_count_idx : held_count;
    end
  end

  ssiu_load_hold u_vm_hold (
    .i_clk          (i_clk),
    .i_reset_n      (i_reset_n),
    .i_load_issued  (i_vm_load_issued),
    .i_other_issued (fire),
    .o_hold         (vm_hold)
  );

  ssiu_load_hold u_rtc_hold (
    .i_clk          (i_clk),
    .i_reset_n      (i_reset_n),
    .i_load_issued  (i_rtc_load_issued),
    .i_other_issued (fire),
    .o_hold         (rtc_hold)
  );

  ssiu_result_unit u_result (
    .i_op         (cur_op),
    .i_parcel     (cur_parcel),
    .i_dest_data  (i_dest_data),
    .i_src_data   (i_src_data),
    .i_count_data (i_count_data),
    .i_vmask      (i_vmask),
    .i_rtc        (i_rtc),
    .o_result     (result)
  );

  // issue acknowledge and destination reservation, one clock after issue
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_issued       <= 1'b0;
      o_dest_reserve <= 1'b0;
      o_reserve_idx  <= '0;
      issued_long    <= 1'b0;
    end else begin
      o_issued       <= fire;
      o_dest_reserve <= fire;
      o_reserve_idx  <= fire ? cur_dest : o_reserve_idx;
      issued_long    <= fire && !cur_is_imm;
    end
  end

  // results ride a delay line; the join stage sets the write phase
  // the head stage has no upstream, so it shifts in an empty slot
  for (genvar s = 0; s < PIPE_DEPTH; s++) begin : g_pipe
    logic              inject;
    logic              prev_valid;
    logic [IDX_W-1:0]  prev_idx;
    logic [DATA_W-1:0] prev_data;
    if (s == 0) begin : g_head
      assign inject     = fire && !cur_is_imm;
      assign prev_valid = 1'b0;
      assign prev_idx   = '0;
      assign prev_data  = '0;
    end else if (s == IMM_INJECT) begin : g_imm
      assign inject     = fire && cur_is_imm;
      assign prev_valid = pipe_valid[s-1];
      assign prev_idx   = pipe_idx[s-1];
      assign prev_data  = pipe_data[s-1];
    end else begin : g_mid
      assign inject     = 1'b0;
      assign prev_valid = pipe_valid[s-1];
      assign prev_idx   = pipe_idx[s-1];
      assign prev_data  = pipe_data[s-1];
    end
    always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
        pipe_valid[s] <= 1'b0;
        pipe_idx[s]   <= '0;
        pipe_data[s]  <= '0;
      end else if (inject) begin
        pipe_valid[s] <= 1'b1;
        pipe_idx[s]   <= cur_dest;
        pipe_data[s]  <= result;
      end else begin
        pipe_valid[s] <= prev_valid;
        pipe_idx[s]   <= prev_idx;
        pipe_data[s]  <= prev_data;
      end
    end
  end

  // write and release share a clock: phases 14/15 and 6/7 pair up
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_wr_valid     <= 1'b0;
      o_wr_idx       <= '0;
      o_wr_data      <= '0;
      o_dest_release <= 1'b0;
      o_release_idx  <= '0;
    end else begin
      o_wr_valid     <= pipe_valid[PIPE_DEPTH-1];
      o_wr_idx       <= pipe_idx[PIPE_DEPTH-1];
      o_wr_data      <= pipe_data[PIPE_DEPTH-1];
      o_dest_release <= pipe_valid[PIPE_DEPTH-1];
      o_release_idx  <= pipe_idx[PIPE_DEPTH-1];
    end
  end

  long_latency_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    o_issued && issued_long |-> ##6 (o_wr_valid && o_dest_release && o_wr_idx == $past(o_reserve_idx, 6)))
    else $error("long op did not write seven clocks after issue");

  imm_latency_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    o_issued && !issued_long |-> ##2 (o_wr_valid && o_dest_release && o_wr_idx == $past(o_reserve_idx, 2)))
    else $error("immediate did not write three clocks after issue");

  release_pair_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    o_wr_valid |-> o_dest_release && o_release_idx == o_wr_idx)
    else $error("release does not match write");

  mask_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_vm_load_issued |=> !(fire && cur_op == OP_MASK_CPY) [*2])
    else $error("mask copy issued inside load hold");

  rtc_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_rtc_load_issued |=> !(fire && cur_op == OP_RTC_READ) [*2])
    else $error("counter read issued inside load hold");

  stall_keeps_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    slot == SLOT_HELD && !fire |=> slot == SLOT_HELD && $stable(held_op) && $stable(held_dest))
    else $error("held operation changed or was dropped");

  dest_free_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    fire |-> i_sreg_free[cur_dest])
    else $error("issue with busy destination");

  dbl_operands_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    fire && cur_is_dbl |-> i_areg_free[cur_count] && i_sreg_free[cur_src])
    else $error("double shift issued with busy operand");

  copy_vlu_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    fire && cur_is_copy |-> i_vlu_free)
    else $error("copy issued with busy vector logical unit");

  dbl_zero_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    fire && cur_is_dbl && i_count_data > MAX_DBL_COUNT |=> ##6 (o_wr_valid && o_wr_data == '0))
    else $error("oversized double count did not give zero");

  next_issue_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    fire |=> !o_slot_full)
    else $error("issue position not free one clock after issue");
endmodule // ssiu_unit
`default_nettype wire

// >>> ssiu_regfile_model.sv
`default_nettype none
module ssiu_regfile_model
  import ssiu_pkg::*;
(
  // clock
  input  wire logic              i_clk,
  // issue position
  input  wire logic              i_slot_full,
  input  wire logic [IDX_W-1:0]  i_held_dest_idx,
  input  wire logic [IDX_W-1:0]  i_held_src_idx,
  input  wire logic [IDX_W-1:0]  i_held_count_idx,
  input  wire logic [IDX_W-1:0]  i_dest_idx,
  input  wire logic [IDX_W-1:0]  i_src_idx,
  input  wire logic [IDX_W-1:0]  i_count_idx,
  // write back
  input  wire logic              i_wr_valid,
  input  wire logic [IDX_W-1:0]  i_wr_idx,
  input  wire logic [DATA_W-1:0] i_wr_data,
  // operands
  output logic      [DATA_W-1:0] o_dest_data,
  output logic      [DATA_W-1:0] o_src_data,
  output logic      [ADDR_W-1:0] o_count_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] sreg [NREG];
  logic [ADDR_W-1:0] areg [NREG];
  // a held op must read its own registers, not those of the new request
  assign o_dest_data  = sreg[i_slot_full ? i_held_dest_idx : i_dest_idx];
  assign o_src_data   = sreg[i_slot_full ? i_held_src_idx : i_src_idx];
  assign o_count_data = areg[i_slot_full ? i_held_count_idx : i_count_idx];
  // plain always: the bench also preloads these arrays between ops
  always @(posedge i_clk) begin
    if (i_wr_valid === 1'b1) begin
      sreg[i_wr_idx] <= i_wr_data;
    end
  end
endmodule // ssiu_regfile_model
`default_nettype wire

// >>> ssiu_unit_tb_top.sv
`default_nettype none
module ssiu_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ssiu_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, valid = 1'b0;
  logic vlu = 1'b1, mfree = 1'b1, rfree = 1'b1, vm_ld = 1'b0, rt_ld = 1'b0;
  ssiu_op_t op = OP_SHL_IMM;
  ssiu_op_t held_op;
  logic [IDX_W-1:0] d = '0, s = '0, c = '0, hd, hs, hc, res_idx, wr_idx, rel_idx;
  logic [PARCEL_W-1:0] parcel = '0;
  logic [NREG-1:0] sfree = '1, afree = '1;
  logic [RSV_W-1:0] rsv = '0;
  logic [DATA_W-1:0] vmask = 64'h5a5a_0f0f_c3c3_9966, rtc = 64'h0123_fedc_ba98_7654;
  logic [DATA_W-1:0] dest_data, src_data, wr_data;
  logic [ADDR_W-1:0] count_data;
  logic slot_full, issued, dres, wr_v, rel;
  int fails = 0, check_count = 0, cyc = 0;
  localparam logic [63:0] DV = 64'h8123_4567_89ab_cdef, SV = 64'hf0e1_d2c3_b4a5_9687;

  ssiu_unit ssiu_unit_i (.i_clk(clk), .i_reset_n(reset_n), .i_issue_valid(valid), .i_op(op),
    .i_dest_idx(d), .i_src_idx(s), .i_count_idx(c), .i_parcel(parcel), .o_slot_full(slot_full),
    .o_held_op(held_op), .o_held_dest_idx(hd), .o_held_src_idx(hs), .o_held_count_idx(hc),
    .o_issued(issued), .i_sreg_free(sfree), .i_areg_free(afree), .i_vlu_free(vlu),
    .i_mask_free(mfree), .i_rtc_free(rfree), .i_wpath_rsv(rsv), .i_vm_load_issued(vm_ld),
    .i_rtc_load_issued(rt_ld), .i_dest_data(dest_data), .i_src_data(src_data),
    .i_count_data(count_data), .i_vmask(vmask), .i_rtc(rtc), .o_dest_reserve(dres),
    .o_reserve_idx(res_idx), .o_wr_valid(wr_v), .o_wr_idx(wr_idx), .o_wr_data(wr_data),
    .o_dest_release(rel), .o_release_idx(rel_idx));
  ssiu_regfile_model ssiu_regfile_model_i (.i_clk(clk), .i_slot_full(slot_full),
    .i_held_dest_idx(hd), .i_held_src_idx(hs), .i_held_count_idx(hc), .i_dest_idx(d),
    .i_src_idx(s), .i_count_idx(c), .i_wr_valid(wr_v), .i_wr_idx(wr_idx), .i_wr_data(wr_data),
    .o_dest_data(dest_data), .o_src_data(src_data), .o_count_data(count_data));

  always #2 clk = ~clk;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // generous bound: each op needs under 40 clocks
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      complete_run();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  function automatic logic [63:0] fl(input logic [63:0] a, input logic [63:0] b, input logic [31:0] n);
    logic [127:0] t;
    t = {a, b} << n;
    return (n >= 128) ? 64'h0 : t[127:64];
  endfunction

  function automatic logic [63:0] fr(input logic [63:0] a, input logic [63:0] b, input logic [31:0] n);
    logic [127:0] t;
    t = {b, a} >> n;
    return (n >= 128) ? 64'h0 : t[63:0];
  endfunction

  task automatic free_all();
    sfree <= '1;
    afree <= '1;
    vlu <= 1'b1;
    mfree <= 1'b1;
    rfree <= 1'b1;
    rsv <= '0;
  endtask

  // bk picks one resource to block until edge number hold after the first attempt
  task automatic run_op(input ssiu_op_t o, input logic [31:0] cnt, input logic [5:0] p,
                        input int bk, input int hold, input logic [63:0] exp);
    int k;
    int m;
    // let the previous result land first, or it overwrites the preload
    @(posedge clk);
    #1;
    ssiu_regfile_model_i.sreg[3] = DV;
    ssiu_regfile_model_i.sreg[5] = SV;
    ssiu_regfile_model_i.areg[6] = cnt;
    @(posedge clk);
    if (bk == 8) vm_ld <= 1'b1;
    if (bk == 9) rt_ld <= 1'b1;
    if (bk >= 8) @(posedge clk);
    vm_ld <= 1'b0;
    rt_ld <= 1'b0;
    valid <= 1'b1;
    op <= o;
    d <= 3'h3;
    s <= 3'h5;
    c <= 3'h6;
    parcel <= p;
    case (bk)
      1: sfree <= 8'hf7;
      2: sfree <= 8'hdf;
      3: afree <= 8'hbf;
      4: vlu <= 1'b0;
      5: mfree <= 1'b0;
      6: rfree <= 1'b0;
      7: rsv <= '1;
      default: ;
    endcase
    for (k = 1; k < 30; k++) begin
      @(posedge clk);
      if (k == 1) valid <= 1'b0;
      if (k == hold) free_all();
      #1;
      if (issued === 1'b1) break;
      check(slot_full, 1'b1, "op not held while blocked");
      check(held_op, o, "held op changed");
      check(hd, 3'h3, "held destination changed");
    end
    check(k - 1, hold, "issue wait");
    check({dres, res_idx}, 4'hb, "destination reserve");
    for (m = 1; m < 20; m++) begin
      @(posedge clk);
      #1;
      if (wr_v === 1'b1) break;
    end
    check(m, (o == OP_IMM_POS || o == OP_IMM_NEG) ? IMM_WR_CYC - 1 : LONG_WR_CYC - 1, "write time");
    check({rel, rel_idx, wr_idx}, 7'h5b, "write and release index");
    check(wr_data, exp, "result");
  endtask

  task automatic back_to_back();
    @(posedge clk);
    valid <= 1'b1;
    op <= OP_IMM_POS;
    d <= 3'h1;
    parcel <= 6'h11;
    @(posedge clk);
    op <= OP_IMM_NEG;
    d <= 3'h2;
    parcel <= 6'h22;
    #1;
    check(issued, 1'b1, "first of pair");
    @(posedge clk);
    valid <= 1'b0;
    #1;
    check({issued, slot_full}, 2'h2, "second of pair next clock");
    @(posedge clk);
    #1;
    check({wr_v, wr_idx}, 4'h9, "first pair write index");
    check(wr_data, 64'h11, "first pair result");
    @(posedge clk);
    #1;
    check({wr_v, wr_idx}, 4'ha, "second pair write index");
    check(wr_data, {58'h3ff_ffff_ffff_ffff, 6'h22}, "second pair result");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    run_op(OP_SHL_IMM, 32'h0, 6'h3f, 0, 0, DV << 63);
    run_op(OP_SHL_IMM, 32'h0, 6'h00, 0, 0, DV);
    run_op(OP_SHR_IMM, 32'h0, 6'h3f, 0, 0, 64'h1);
    run_op(OP_SHR_IMM, 32'h0, 6'h04, 0, 0, DV >> 4);
    run_op(OP_SHL_DBL, 32'h40, 6'h0, 0, 0, SV);
    run_op(OP_SHL_DBL, 32'h0, 6'h0, 0, 0, DV);
    run_op(OP_SHL_DBL, 32'h81, 6'h0, 0, 0, 64'h0);
    run_op(OP_SHL_DBL, 32'h8000_0001, 6'h0, 0, 0, 64'h0);
    run_op(OP_SHL_DBL, 32'h5, 6'h0, 3, 2, fl(DV, SV, 5));
    run_op(OP_SHR_DBL, 32'h40, 6'h0, 2, 1, SV);
    run_op(OP_SHR_DBL, 32'h3, 6'h0, 0, 0, fr(DV, SV, 3));
    run_op(OP_SHR_DBL, 32'h80, 6'h0, 0, 0, 64'h0);
    run_op(OP_MASK_CPY, 32'h0, 6'h0, 4, 3, vmask);
    run_op(OP_MASK_CPY, 32'h0, 6'h0, 5, 1, vmask);
    run_op(OP_MASK_CPY, 32'h0, 6'h0, 8, 2, vmask);
    run_op(OP_RTC_READ, 32'h0, 6'h0, 6, 1, rtc);
    run_op(OP_RTC_READ, 32'h0, 6'h0, 9, 2, rtc);
    run_op(OP_IMM_POS, 32'h0, 6'h2a, 1, 3, 64'h2a);
    run_op(OP_IMM_NEG, 32'h0, 6'h15, 7, 1, {58'h3ff_ffff_ffff_ffff, 6'h15});
    run_op(OP_SHL_IMM, 32'h0, 6'h01, 7, 2, DV << 1);
    back_to_back();
    complete_run();
  end
endmodule // ssiu_unit_tb_top
`default_nettype wire
